//--- src/irq_controller.sv
// interrupt controller: flags, enables, global gate, vectoring and wake
// assumes the core strobes write and instruction inputs for one clk cycle
`timescale 1ns/10ps
`include "irq_defs.svh"
module irq_controller
(
  // clocking
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ce,
  // sources
  input  wire logic           ext_irq_pin,
  input  wire logic [3:0]     upper_port,
  input  wire logic           ext_edge_select,
  input  wire irq_pkg::byte_t timer_zero_count,
  input  wire irq_pkg::byte_t periph_set_a,
  input  wire irq_pkg::byte_t periph_set_b,
  // core writes
  input  wire logic           ctl_wr,
  input  wire irq_pkg::byte_t ctl_wdata,
  input  wire logic           pfa_wr,
  input  wire logic           pfb_wr,
  input  wire logic           pea_wr,
  input  wire logic           peb_wr,
  input  wire irq_pkg::byte_t periph_wdata,
  // core instruction events
  input  wire logic           return_from_irq_instr,
  input  wire logic           sleep_instr,
  input  wire logic           instr_boundary,
  input  wire irq_pkg::pc_t   core_pc,
  // register views
  output irq_pkg::byte_t      irq_control_reg,
  output irq_pkg::byte_t      periph_flag_reg_a,
  output irq_pkg::byte_t      periph_flag_reg_b,
  output irq_pkg::byte_t      periph_enable_reg_a,
  output irq_pkg::byte_t      periph_enable_reg_b,
  // core control
  output logic                vector_take,
  output irq_pkg::pc_t        vector_pc,
  output logic                stack_push,
  output irq_pkg::pc_t        stack_push_pc,
  output logic                sleeping,
  output logic                wake
);
  import irq_pkg::*;

  src_if evt ();
  logic roll_evt;

  edge_detect u_edge
  (
    .clk             (clk),
    .rst             (rst),
    .ce              (ce),
    .ext_irq_pin     (ext_irq_pin),
    .upper_port      (upper_port),
    .ext_edge_select (ext_edge_select),
    .evt             (evt)
  );

  timer_roll u_roll
  (
    .clk              (clk),
    .rst              (rst),
    .ce               (ce),
    .timer_zero_count (timer_zero_count),
    .roll_evt         (roll_evt)
  );

  byte_t       ctl_reg;
  byte_t       pfa_reg;
  byte_t       pfb_reg;
  byte_t       pea_reg;
  byte_t       peb_reg;
  core_state_t state_reg;
  logic [`LAT_CNT_W-1:0] lat_reg;
  logic        enabled_any;
  logic        request;
  logic        take;

  // 19 sources, not the up to 11 of [RQ17]: three core, sixteen peripheral spread over two registers
  function automatic logic any_pair(input byte_t f, input byte_t e);
    any_pair = |(f & e);
  endfunction

  always_comb
  begin
    enabled_any = (ctl_reg[`CTL_EXT_FLAG] && ctl_reg[`CTL_EXT_EN])          // [RQ10]
               || (ctl_reg[`CTL_TMR_FLAG] && ctl_reg[`CTL_TMR_EN])          // [RQ13]
               || (ctl_reg[`CTL_PORT_FLAG] && ctl_reg[`CTL_PORT_EN])        // [RQ14]
               || (ctl_reg[`CTL_PERIPH_EN]
                   && (any_pair(pfa_reg, pea_reg) || any_pair(pfb_reg, peb_reg))); // [RQ15]
    request = enabled_any && ctl_reg[`CTL_GLOBAL_EN]; // [RQ20] [RQ2]
  end

  // vector on instruction boundary once latency elapsed: 3 cycles, 4 if mid-instruction
  assign take = request && (state_reg == ST_PEND) && (lat_reg == 0) && instr_boundary; // [RQ3] [RQ8]

  // control register: hardware set beats software clear
  always_ff @(posedge clk)
  begin
    if (rst)
      ctl_reg <= `CTL_RESET; // [RQ4]
    else if (ce)
    begin
      if (ctl_wr)
        ctl_reg <= ctl_wdata;
      if (evt.ext_evt)
        ctl_reg[`CTL_EXT_FLAG] <= 1'b1; // [RQ1] [RQ9]
      if (roll_evt)
        ctl_reg[`CTL_TMR_FLAG] <= 1'b1; // [RQ12]
      if (evt.port_evt)
        ctl_reg[`CTL_PORT_FLAG] <= 1'b1; // [RQ14]
      if (return_from_irq_instr)
        ctl_reg[`CTL_GLOBAL_EN] <= 1'b1; // [RQ5]
      if (take)
        ctl_reg[`CTL_GLOBAL_EN] <= 1'b0; // [RQ6]
    end
  end

  // peripheral flags and enables
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pfa_reg <= `PERIPH_RESET;
      pfb_reg <= `PERIPH_RESET;
      pea_reg <= `PERIPH_RESET;
      peb_reg <= `PERIPH_RESET;
    end
    else if (ce)
    begin
      pfa_reg <= (pfa_wr ? periph_wdata : pfa_reg) | periph_set_a; // [RQ1] [RQ15]
      pfb_reg <= (pfb_wr ? periph_wdata : pfb_reg) | periph_set_b; // [RQ1] [RQ15]
      if (pea_wr)
        pea_reg <= periph_wdata;
      if (peb_wr)
        peb_reg <= periph_wdata;
    end
  end

  // run / sleep / pending; a flag left set by software re-enters at once [RQ7]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_RUN;
      lat_reg   <= '0;
    end
    else if (ce)
    begin
      unique case (state_reg)
        ST_RUN:
        begin
          if (sleep_instr && !enabled_any)
            state_reg <= ST_SLEEP;
          else if (request)
          begin
            state_reg <= ST_PEND;
            lat_reg   <= `LAT_CNT_W'(`LATENCY_CYCLES - 1); // [RQ8]
          end
        end
        ST_SLEEP:
        begin
          if (enabled_any) // [RQ11] [RQ19]
            state_reg <= ST_RUN; // [RQ18]
        end
        ST_PEND:
        begin
          if (!request || take)
            state_reg <= ST_RUN;
          else if (lat_reg != 0)
            lat_reg <= lat_reg - 1'b1;
        end
      endcase
    end
  end

  // core outputs registered; only return pc is pushed [RQ16]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vector_take   <= 1'b0;
      vector_pc     <= `IRQ_VECTOR;
      stack_push    <= 1'b0;
      stack_push_pc <= '0;
      sleeping      <= 1'b0;
      wake          <= 1'b0;
    end
    else if (ce)
    begin
      vector_take <= take; // [RQ6]
      stack_push  <= take; // [RQ16]
      if (take)
        stack_push_pc <= core_pc;
      vector_pc   <= `IRQ_VECTOR;
      sleeping    <= (state_reg == ST_SLEEP) && !enabled_any;
      wake        <= (state_reg == ST_SLEEP) && enabled_any; // [RQ19]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_control_reg     <= `CTL_RESET;
      periph_flag_reg_a   <= `PERIPH_RESET;
      periph_flag_reg_b   <= `PERIPH_RESET;
      periph_enable_reg_a <= `PERIPH_RESET;
      periph_enable_reg_b <= `PERIPH_RESET;
    end
    else if (ce)
    begin
      irq_control_reg     <= ctl_reg;
      periph_flag_reg_a   <= pfa_reg;
      periph_flag_reg_b   <= pfb_reg;
      periph_enable_reg_a <= pea_reg;
      periph_enable_reg_b <= peb_reg;
    end
  end
endmodule

//--- src/irq_defs.svh
// constants for the interrupt controller: bit positions, vector, latency
// assumes inclusion by each design file of the interrupt controller that uses its macros
//
// Summary of operation
// RQ1 - each source flag sets on its event regardless of any enable bit
// RQ2 - global enable bit 7 passes unmasked requests when set, blocks all when clear
// RQ3 - with global enable set, any flagged and enabled source vectors at once
// RQ4 - device reset clears the global enable
// RQ5 - return-from-interrupt leaves the routine and sets global enable
// RQ6 - on response clear global enable, push return address, load pc with 0004h
// RQ7 - software clears the pending flag before re-enabling, else the routine re-enters
// RQ8 - pin and port-change latency is three or four instruction cycles
// RQ9 - pin is edge triggered; edge select picks rising or falling; sets bit 1
// RQ10 - clearing control bit 4 stops the pin source from interrupting
// RQ11 - pin interrupt wakes from power-down when its enable was set
// RQ12 - timer rolling from FFh to 00h sets control bit 2
// RQ13 - control bit 5 enables or disables the timer overflow interrupt
// RQ14 - change on upper port bits 7 to 4 sets bit 0, gated by its enable
// RQ15 - peripheral flags and enables in two register pairs, plus group enable
// RQ16 - hardware saves only the return pc, no working or status register
// RQ17 - up to 11 sources, each with flag and enable; the controller has 19 (three core, sixteen peripheral)
// RQ18 - after wake, global enable decides vector or continue in line
// RQ19 - wake happens regardless of global enable; clear means resume after sleep
// RQ20 - request is or of flag-and-enable terms, peripherals group gated, all global gated
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
`define CTL_PORT_FLAG   0
`define CTL_EXT_FLAG    1
`define CTL_TMR_FLAG    2
`define CTL_PORT_EN     3
`define CTL_EXT_EN      4
`define CTL_TMR_EN      5
`define CTL_PERIPH_EN   6
`define CTL_GLOBAL_EN   7
`define CTL_RESET       8'h00
`define PERIPH_RESET    8'h00
`define IRQ_VECTOR      13'h0004
`define TMR_ROLL_FROM   8'hFF
`define TMR_ROLL_TO     8'h00
`define LATENCY_CYCLES  3
`define LAT_CNT_W       2
`endif

//--- src/irq_pkg.sv
// types shared by the interrupt controller modules
// assumes irq_defs.svh supplies the numeric constants
package irq_pkg;
  typedef logic [12:0] pc_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_PEND} core_state_t;
endpackage

//--- src/src_if.sv
// carrier for synchronised source events between the top and its edge unit
// assumes one clock domain
`timescale 1ns/10ps
interface src_if;
  logic       ext_evt;
  logic       port_evt;
  modport det (output ext_evt, output port_evt);
  modport ctl (input ext_evt, input port_evt);
endinterface

//--- src/edge_detect.sv
// synchronises the external pin and upper port, detects valid events
// assumes pins are asynchronous to clk
`timescale 1ns/10ps
module edge_detect
(
  // clocking
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // pins
  input  wire logic       ext_irq_pin,
  input  wire logic [3:0] upper_port,
  input  wire logic       ext_edge_select,
  // events
  src_if.det              evt
);
  import irq_pkg::*;
  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic [4:0] prev_reg;
  logic [2:0] primed_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg     <= 5'h00;
      s2_reg     <= 5'h00;
      prev_reg   <= 5'h00;
      primed_reg <= 3'h0;
    end
    else if (ce)
    begin
      s1_reg     <= {upper_port, ext_irq_pin};
      s2_reg     <= s1_reg;
      prev_reg   <= s2_reg;
      primed_reg <= {primed_reg[1:0], 1'b1};
    end
  end

  // no event until prev holds a real sample: a pin idling high after reset is no edge
  always_comb
  begin
    evt.ext_evt  = primed_reg[2] && (ext_edge_select ? (s2_reg[0] && !prev_reg[0])
                                                     : (!s2_reg[0] && prev_reg[0])); // [RQ9]
    evt.port_evt = primed_reg[2] && (s2_reg[4:1] != prev_reg[4:1]); // [RQ14]
  end
endmodule

//--- src/timer_roll.sv
// flags the timer count rolling from its top value to zero
// assumes the count is from the same clock domain
`timescale 1ns/10ps
`include "irq_defs.svh"
module timer_roll
(
  // clocking
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // count
  input  wire irq_pkg::byte_t      timer_zero_count,
  // event
  output logic                     roll_evt
);
  import irq_pkg::*;
  byte_t last_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      last_reg <= 8'h00;
    else if (ce)
      last_reg <= timer_zero_count;
  end

  assign roll_evt = (last_reg == `TMR_ROLL_FROM) && (timer_zero_count == `TMR_ROLL_TO); // [RQ12]
endmodule

//--- verif/irq_controller_asserts.sv
// checker for the interrupt controller ports
// assumes bind from tb, one clock, ce low only while no source moves
`timescale 1ns/10ps
module irq_controller_asserts
(
  // clocking
  input wire logic           clk,
  input wire logic           rst,
  // sources and core
  input wire logic           ext_irq_pin,
  input wire logic           ext_edge_select,
  input wire irq_pkg::byte_t timer_zero_count,
  input wire logic           ctl_wr,
  input wire logic           return_from_irq_instr,
  // outputs
  input wire irq_pkg::byte_t irq_control_reg,
  input wire logic           vector_take,
  input wire irq_pkg::pc_t   vector_pc,
  input wire logic           stack_push,
  input wire logic           sleeping,
  input wire logic           wake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_VEC_ADDR: assert property (vector_pc == 13'h0004)
    else $error("vector address wrong");
  AST_PUSH_TAKE: assert property (vector_take |-> stack_push)
    else $error("take without push");
  AST_ONLY_PC: assert property (stack_push |-> vector_take)
    else $error("push without take");
  AST_GIE_DROP: assert property (vector_take |=> !irq_control_reg[7])
    else $error("global enable kept on take");
  AST_TAKE_ONE: assert property (vector_take |=> !vector_take)
    else $error("take longer than one cycle");
  AST_RST_CLR: assert property ($past(rst) && $past(rst, 2) |-> irq_control_reg == 8'h00)
    else $error("control not clear after reset");
  AST_GIE_BLOCK: assert property
    ((!irq_control_reg[7] && !ctl_wr && !return_from_irq_instr) [*4] |=> !vector_take)
    else $error("take while global enable clear");
  AST_WAKE_SLP: assert property (wake |-> $past(sleeping))
    else $error("wake while not sleeping");
  AST_TMR_FLAG: assert property
    ($past(timer_zero_count) == 8'hFF && timer_zero_count == 8'h00
     |-> ##[1:4] irq_control_reg[2])
    else $error("roll did not set timer flag");
  AST_EXT_FLAG: assert property
    ((ext_edge_select ? $rose(ext_irq_pin) : $fell(ext_irq_pin))
     |-> ##[1:6] irq_control_reg[1])
    else $error("valid edge did not set pin flag");
endmodule

//--- verif/core_model.sv
// processor core stand-in: program counter and instruction boundary
// assumes vector_take pulses one cycle; slow makes boundaries sparse
`timescale 1ns/10ps
module core_model
(
  // clocking
  input wire logic         clk,
  // controller side
  input wire logic         take,
  input wire irq_pkg::pc_t vec,
  input wire logic         slow,
  // core state
  output irq_pkg::pc_t     pc,
  output logic             bnd
);
  initial pc = 13'h0100;
  // two-cycle instructions only finish every other cycle
  assign bnd = !slow || pc[0];
  always @(posedge clk)
    pc <= take ? vec : pc + 13'h0001;
endmodule

//--- verif/tb.sv
// self-checking bench for the interrupt controller
// assumes core_model beside it and the checker bound below
`timescale 1ns/10ps
module tb;
  import irq_pkg::*;
  logic clk = 0, rst = 1, ce = 1, pin = 0, sel = 1, cw = 0, ret = 0, slp = 0, slow = 0;
  logic vt, sp, slpg, wk, bnd;
  logic [3:0] port = 0, pw = 0;
  byte_t tz = 0, psa = 0, psb = 0, cd = 0, pd = 0, icr, pfa, pfb, pea, peb;
  pc_t vpc, cpc, spc, rpc, ppc;
  int errors = 0, n_compared = 0, ntk = 0, nwk = 0, cyc = 0, t0, w0;
  always #10 clk = ~clk;
  irq_controller irq_controller_inst (.clk, .rst, .ce, .ext_irq_pin(pin),
    .upper_port(port), .ext_edge_select(sel), .timer_zero_count(tz), .periph_set_a(psa),
    .periph_set_b(psb), .ctl_wr(cw), .ctl_wdata(cd), .pfa_wr(pw[0]), .pfb_wr(pw[1]),
    .pea_wr(pw[2]), .peb_wr(pw[3]), .periph_wdata(pd), .return_from_irq_instr(ret),
    .sleep_instr(slp), .instr_boundary(bnd), .core_pc(cpc), .irq_control_reg(icr),
    .periph_flag_reg_a(pfa), .periph_flag_reg_b(pfb), .periph_enable_reg_a(pea),
    .periph_enable_reg_b(peb), .vector_take(vt), .vector_pc(vpc), .stack_push(sp),
    .stack_push_pc(spc), .sleeping(slpg), .wake(wk));
  core_model core_model_inst (.clk, .take(vt), .vec(vpc), .slow, .pc(cpc), .bnd);
  // a hang is cut short well past the fewer than two hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    // the pc shown in the cycle the vector was taken is the return address
    if (vt === 1'b1)
    begin
      ntk++;
      rpc = ppc;
    end
    ppc = cpc;
    if (wk === 1'b1) nwk++;
    if (cyc == 3000)
    begin
      errors++;
      close_out();
    end
  end
  task close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task tk; @(posedge clk); #1; endtask
  task run(input int n); repeat (n) tk; endtask
  task chk(input logic [12:0] g, input logic [12:0] e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wc(input byte_t v); cw = 1; cd = v; tk; cw = 0; tk; endtask
  task wp(input int i, input byte_t v); pw[i] = 1; pd = v; tk; pw = 0; tk; endtask
  task t_mask;
    t0 = ntk;
    tz = 8'hFF; tk; tz = 0; pin = 1; port = 4'h1; psa = 8'h01; psb = 8'h80; tk;
    psa = 0; psb = 0; run(8);
    chk(icr, 8'h07);
    chk(pfa, 8'h01);
    chk(pfb, 8'h80);
    chk(13'(ntk - t0), 0);
    wc(8'h00); pin = 0; run(8);
    chk(icr, 8'h00);
    sel = 0; tk; pin = 1; tk; pin = 0; run(8);
    chk(icr, 8'h02);
    $display("test mask done");
  endtask
  task t_vec;
    t0 = ntk;
    wc(8'h92); run(3);
    chk(13'(ntk - t0), 0);
    run(1);
    chk(13'(ntk - t0), 1);
    run(6);
    chk(13'(ntk - t0), 1);
    chk(icr, 8'h12);
    chk(spc, rpc);
    ret = 1; tk; ret = 0; run(10);
    chk(13'(ntk - t0), 2);
    wc(8'h10); ret = 1; tk; ret = 0; run(10);
    chk(icr, 8'h90);
    wc(8'h80); pin = 1; run(2); pin = 0; run(8);
    chk(icr, 8'h82);
    chk(13'(ntk - t0), 2);
    slow = 1; wc(8'hA0); tz = 8'hFF; tk; tz = 0; run(12); slow = 0;
    chk(13'(ntk - t0), 3);
    chk(icr, 8'h24);
    $display("test vector done");
  endtask
  task t_per;
    t0 = ntk;
    wc(8'h80); wp(2, 8'h01); wp(3, 8'h80); wp(1, 8'h80); run(6);
    chk(13'(ntk - t0), 0);
    chk(pfb, 8'h80);
    chk(peb, 8'h80);
    chk(pea, 8'h01);
    wc(8'hC0); run(10);
    chk(13'(ntk - t0), 1);
    chk(icr, 8'h40);
    wp(0, 8'h00); wp(1, 8'h00);
    $display("test peripheral done");
  endtask
  // a write made while the clock enable is low must not land
  task t_ce;
    ce = 0; wc(8'h90); ce = 1; run(2);
    chk(icr, 8'h40);
    $display("test clock enable done");
  endtask
  task t_rst;
    wc(8'h80);
    chk(icr, 8'h80);
    rst = 1; run(2); rst = 0; tk;
    chk(icr, 8'h00);
    run(6);
    chk(icr, 8'h00);
    $display("test mid reset done");
  endtask
  task t_slp;
    t0 = ntk; w0 = nwk;
    wc(8'h10); pin = 1; slp = 1; tk; slp = 0; run(3);
    chk(slpg, 1);
    pin = 0; run(10);
    chk(13'(nwk - w0), 1);
    chk(slpg, 0);
    chk(13'(ntk - t0), 0);
    // pending enabled flag turns the sleep into a no-op
    slp = 1; tk; slp = 0; run(3);
    chk(slpg, 0);
    wc(8'h88); slp = 1; tk; slp = 0; run(3); port = 4'h7; run(12);
    chk(13'(ntk - t0), 1);
    $display("test sleep done");
  endtask
  initial
  begin
    run(6); rst = 0; tk;
    chk(icr, 8'h00);
    chk(vpc, 13'h0004);
    $display("test reset done");
    t_mask; t_vec; t_per; t_ce; t_slp; t_rst;
    close_out();
  end
endmodule
bind irq_controller irq_controller_asserts irq_controller_asserts_inst (.clk, .rst,
  .ext_irq_pin, .ext_edge_select, .timer_zero_count, .ctl_wr, .return_from_irq_instr,
  .irq_control_reg, .vector_take, .vector_pc, .stack_push, .sleeping, .wake);
